// ### rtl/tpc_count.sv
// Prescaled up-counter with programmable period, used by every timer.
// Assumes i_evt and i_ext_tick are one-cycle pulses on i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module tpc_count #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_arst_n,
    // Control
    input  wire logic [1:0]   i_mode,
    input  wire logic [2:0]   i_presc,
    input  wire logic [W-1:0] i_period,
    input  wire logic         i_evt,
    input  wire logic         i_ext_sel,
    input  wire logic         i_ext_tick,
    // Status
    output logic      [W-1:0] o_count,
    output logic              o_wrap
);
    logic [7:0]   pdiv_ff;
    logic [7:0]   pmask;
    logic         pre_tick;
    logic         tick;
    logic [W-1:0] cnt_ff;
    logic         wrap_ff;

    // -------------------------------------------------------------------
    // Prescaler: divide by 2**presc
    // -------------------------------------------------------------------
    assign pmask    = (tpc_pkg::PDIV_ONE << i_presc) - tpc_pkg::PDIV_ONE;
    assign pre_tick = (pdiv_ff & pmask) == pmask; // R2

    always_comb begin
        case (tpc_pkg::tpc_mode_t'(i_mode))
            tpc_pkg::TPC_TIMER: tick = i_ext_sel ? i_ext_tick : pre_tick;
            tpc_pkg::TPC_EVENT: tick = i_evt; // R1
            default:            tick = 1'b0;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pdiv_ff <= tpc_pkg::PDIV_RST;
        end else if (i_mode == tpc_pkg::TPC_STOP) begin
            pdiv_ff <= tpc_pkg::PDIV_RST;
        end else begin
            pdiv_ff <= pdiv_ff + tpc_pkg::PDIV_ONE;
        end
    end

    // -------------------------------------------------------------------
    // Counter: 0 .. period, then back to 0
    // -------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_ff <= '0;
        end else if (tick) begin
            if (cnt_ff == i_period) begin
                cnt_ff <= '0; // R10
            end else begin
                // Period lowered below count: runs on to natural rollover
                cnt_ff <= cnt_ff + W'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wrap_ff <= 1'b0;
        end else begin
            wrap_ff <= tick && (cnt_ff == i_period); // R10
        end
    end

    assign o_count = cnt_ff;
    assign o_wrap  = wrap_ff;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    a_cnt_wrap: assert property (tick && cnt_ff == i_period |=> // R10
        cnt_ff == '0 && o_wrap) else $error("counter did not wrap");
    a_cnt_step: assert property (tick && cnt_ff != i_period |=> // R1
        cnt_ff == $past(cnt_ff) + W'(1)) else $error("counter step wrong");
    a_cnt_hold: assert property (!tick |=> $stable(cnt_ff)) // R2
        else $error("counter moved without tick");
    a_presc_gap: assert property ( // R2
        i_mode == tpc_pkg::TPC_TIMER && !i_ext_sel && i_presc == 3'h1
        && $stable(i_presc) && pre_tick |=> !pre_tick)
        else $error("prescaler by two ticked twice");
    c_wrap: cover property (o_wrap);
endmodule
`default_nettype wire

// ### rtl/tpc_pkg.sv
// Constants shared by the timer group: widths, modes, prescaler layout.
// Assumes a single 200 MHz clock and an active-low async reset.
package tpc_pkg;
    // -------------------------------------------------------------------
    // Widths and counts
    // -------------------------------------------------------------------
    localparam int MAIN_W  = 16;
    localparam int SMALL_W = 8;
    localparam int MAIN_CH = 5;
    localparam int PRE_W   = 3;
    localparam int PDIV_W  = 8;
    localparam int SYNC_N  = 8;
    // Sync vector layout: capture pins, then event pins
    localparam int SYN_CAP = 0;
    localparam int SYN_EV1 = 5;
    localparam int SYN_EV3 = 6;
    localparam int SYN_EV4 = 7;

    // -------------------------------------------------------------------
    // Counter operating modes
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        TPC_STOP  = 2'b00,
        TPC_TIMER = 2'b01,
        TPC_EVENT = 2'b10,
        TPC_RSVD  = 2'b11
    } tpc_mode_t;

    localparam logic [PDIV_W-1:0] PDIV_ONE = 8'h01;
    localparam logic [PDIV_W-1:0] PDIV_RST = 8'h00;
endpackage

// ### rtl/tpc_timer_group.sv
// Timer group: 16-bit main timer with five compare/capture channels,
// two 8-bit timers with one PWM channel each, and infrared modulation.
// Assumes pins are asynchronous; controls are static, same-clock levels.
//
// Contract
// [R1] Main timer is a 16-bit timer, event counter or PWM source.
// [R2] Main timer count clock passes a prescaler; period value bounds it.
// [R3] Main timer has five channels, each with its own 16-bit compare.
// [R4] Each main channel drives PWM or captures count on an input edge.
// [R5] Infrared mode: main timer advances once per first small-timer period.
// [R6] Infrared output is main timer output AND first small-timer output.
// [R7] Each small timer is an 8-bit timer, event counter or PWM source.
// [R8] Small timers: prescaler, 8-bit period, exactly one 8-bit compare.
// [R9] Small-timer channel produces PWM from compare value and counter.
// [R10] Counters run zero to period, restart at zero, one wrap each.
// [R11] PWM output changes at compare match and is restored at wrap.
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_group #(
    parameter int MW = tpc_pkg::MAIN_W,
    parameter int SW = tpc_pkg::SMALL_W,
    parameter int NC = tpc_pkg::MAIN_CH
) (
    // Clock and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_arst_n,
    // Main timer control
    input  wire logic [1:0]      i_t1_mode,
    input  wire logic [2:0]      i_t1_presc,
    input  wire logic [MW-1:0]   i_t1_period,
    input  wire logic [NC*MW-1:0] i_t1_cmp,
    input  wire logic [NC-1:0]   i_t1_ch_en,
    input  wire logic [NC-1:0]   i_t1_ch_cap,
    input  wire logic [NC-1:0]   i_t1_cap_fall,
    // Small timer control
    input  wire logic [1:0]      i_t3_mode,
    input  wire logic [2:0]      i_t3_presc,
    input  wire logic [SW-1:0]   i_t3_period,
    input  wire logic [SW-1:0]   i_t3_cmp,
    input  wire logic            i_t3_ch_en,
    input  wire logic [1:0]      i_t4_mode,
    input  wire logic [2:0]      i_t4_presc,
    input  wire logic [SW-1:0]   i_t4_period,
    input  wire logic [SW-1:0]   i_t4_cmp,
    input  wire logic            i_t4_ch_en,
    input  wire logic            i_ir_en,
    // Pins
    input  wire logic [NC-1:0]   i_t1_cap_pin,
    input  wire logic            i_t1_evt_pin,
    input  wire logic            i_t3_evt_pin,
    input  wire logic            i_t4_evt_pin,
    // Main timer status and outputs
    output logic      [MW-1:0]   o_t1_count,
    output logic                 o_t1_wrap,
    output logic      [NC-1:0]   o_t1_pwm,
    output logic      [NC*MW-1:0] o_t1_capt,
    output logic      [NC-1:0]   o_t1_capt_stb,
    // Small timer status and outputs
    output logic      [SW-1:0]   o_t3_count,
    output logic                 o_t3_wrap,
    output logic                 o_t3_pwm,
    output logic      [SW-1:0]   o_t4_count,
    output logic                 o_t4_wrap,
    output logic                 o_t4_pwm,
    // Infrared output
    output logic                 o_ir_out
);
    localparam int SN = tpc_pkg::SYNC_N;

    logic [SN-1:0]    pin_raw;
    logic [SN-1:0]    sync1_ff;
    logic [SN-1:0]    sync2_ff;
    logic [SN-1:0]    sync3_ff;
    logic [SN-1:0]    rise;
    logic [SN-1:0]    fall;
    logic [NC-1:0]    pwm_ff;
    logic [NC-1:0]    stb_ff;
    logic [NC*MW-1:0] capt_ff;
    logic             t3_pwm_ff;
    logic             t4_pwm_ff;
    logic             ir_ff;

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    assign pin_raw = {i_t4_evt_pin, i_t3_evt_pin, i_t1_evt_pin, i_t1_cap_pin};

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~sync3_ff;
    assign fall = ~sync2_ff & sync3_ff;

    // -------------------------------------------------------------------
    // Counters
    // -------------------------------------------------------------------
    // Infrared mode: main timer counts first small-timer periods
    tpc_count #(.W(MW)) u_t1 (
        .i_ref_clk  (i_ref_clk),
        .i_arst_n   (i_arst_n),
        .i_mode     (i_t1_mode),
        .i_presc    (i_t1_presc),
        .i_period   (i_t1_period),
        .i_evt      (rise[tpc_pkg::SYN_EV1]),
        .i_ext_sel  (i_ir_en), // R5
        .i_ext_tick (o_t3_wrap),
        .o_count    (o_t1_count),
        .o_wrap     (o_t1_wrap)
    ); // R1 R2

    tpc_count #(.W(SW)) u_t3 (
        .i_ref_clk  (i_ref_clk),
        .i_arst_n   (i_arst_n),
        .i_mode     (i_t3_mode),
        .i_presc    (i_t3_presc),
        .i_period   (i_t3_period),
        .i_evt      (rise[tpc_pkg::SYN_EV3]),
        .i_ext_sel  (1'b0),
        .i_ext_tick (1'b0),
        .o_count    (o_t3_count),
        .o_wrap     (o_t3_wrap)
    ); // R7 R8

    tpc_count #(.W(SW)) u_t4 (
        .i_ref_clk  (i_ref_clk),
        .i_arst_n   (i_arst_n),
        .i_mode     (i_t4_mode),
        .i_presc    (i_t4_presc),
        .i_period   (i_t4_period),
        .i_evt      (rise[tpc_pkg::SYN_EV4]),
        .i_ext_sel  (1'b0),
        .i_ext_tick (1'b0),
        .o_count    (o_t4_count),
        .o_wrap     (o_t4_wrap)
    ); // R7 R8

    // -------------------------------------------------------------------
    // Main timer channels
    // -------------------------------------------------------------------
    // High from wrap until the counter reaches compare, so compare 0
    // gives a constant low and compare above period a constant high.
    for (genvar c = 0; c < NC; c++) begin : g_ch
        logic [MW-1:0] cmp;
        logic          edge_hit;
        assign cmp      = i_t1_cmp[c*MW +: MW];
        assign edge_hit = i_t1_cap_fall[c] ? fall[tpc_pkg::SYN_CAP + c]
                                           : rise[tpc_pkg::SYN_CAP + c];

        always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                pwm_ff[c] <= 1'b0;
            end else if (i_t1_ch_en[c] && !i_t1_ch_cap[c]) begin
                pwm_ff[c] <= o_t1_count < cmp; // R11 R3 R4
            end else begin
                pwm_ff[c] <= 1'b0;
            end
        end

        always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                capt_ff[c*MW +: MW] <= '0;
                stb_ff[c]           <= 1'b0;
            end else begin
                stb_ff[c] <= i_t1_ch_en[c] && i_t1_ch_cap[c] && edge_hit;
                if (i_t1_ch_en[c] && i_t1_ch_cap[c] && edge_hit) begin
                    capt_ff[c*MW +: MW] <= o_t1_count; // R4
                end
            end
        end

        a_capt_value: assert property (@(posedge i_ref_clk) // R4
            disable iff (!i_arst_n)
            i_t1_ch_en[c] && i_t1_ch_cap[c] && edge_hit |=>
            stb_ff[c] && capt_ff[c*MW +: MW] == $past(o_t1_count))
            else $error("capture missed or wrong value");
        a_pwm_wrap: assert property (@(posedge i_ref_clk) // R11
            disable iff (!i_arst_n)
            o_t1_wrap && i_t1_ch_en[c] && !i_t1_ch_cap[c]
            && cmp != '0 && $stable(cmp) |=> pwm_ff[c])
            else $error("pwm not restored at wrap");
    end

    // -------------------------------------------------------------------
    // Small timer channels
    // -------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            t3_pwm_ff <= 1'b0;
        end else begin
            t3_pwm_ff <= i_t3_ch_en && (o_t3_count < i_t3_cmp); // R9 R11
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            t4_pwm_ff <= 1'b0;
        end else begin
            t4_pwm_ff <= i_t4_ch_en && (o_t4_count < i_t4_cmp); // R9 R11
        end
    end

    // -------------------------------------------------------------------
    // Infrared modulation
    // -------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ir_ff <= 1'b0;
        end else begin
            ir_ff <= i_ir_en && pwm_ff[0] && t3_pwm_ff; // R6
        end
    end

    assign o_t1_pwm      = pwm_ff;
    assign o_t1_capt     = capt_ff;
    assign o_t1_capt_stb = stb_ff;
    assign o_t3_pwm      = t3_pwm_ff;
    assign o_t4_pwm      = t4_pwm_ff;
    assign o_ir_out      = ir_ff;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_ir_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        $past(i_ir_en) |-> o_ir_out == $past(pwm_ff[0] && t3_pwm_ff)) // R6
        else $error("infrared output not the AND of both");
    a_ir_clock: assert property (@(posedge i_ref_clk) // R5
        disable iff (!i_arst_n)
        $past(i_ir_en) && $past(i_t1_mode) == tpc_pkg::TPC_TIMER
        && $changed(o_t1_count) |-> $past(o_t3_wrap))
        else $error("main timer moved without small-timer wrap");
    a_small_pwm: assert property (@(posedge i_ref_clk) // R9
        disable iff (!i_arst_n)
        i_t3_ch_en && $stable(i_t3_cmp) && o_t3_count == i_t3_cmp
        ##1 i_t3_ch_en |-> !t3_pwm_ff)
        else $error("small pwm not low at compare");
    a_small_bound: assert property (@(posedge i_ref_clk) // R8
        disable iff (!i_arst_n)
        $stable(i_t4_period) && o_t4_count == i_t4_period
        && i_t4_mode == tpc_pkg::TPC_TIMER |-> ##[1:128] o_t4_count == '0)
        else $error("small timer failed to wrap");

    c_ir: cover property (@(posedge i_ref_clk) o_ir_out ##1 !o_ir_out);
    c_capt: cover property (@(posedge i_ref_clk) |o_t1_capt_stb);
    c_pwm: cover property (@(posedge i_ref_clk) o_t1_pwm[0] ##1 !o_t1_pwm[0]);
endmodule
`default_nettype wire

// ### testbench/tb_tpc_timer_group.sv
// Self-checking bench for the timer group.
// Assumes pins come from tpc_pin_model; one 200 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_tpc_timer_group;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  m1 = 2'h0, m3 = 2'h0, m4 = 2'h0;
    logic [2:0]  p1 = 3'h0, p3 = 3'h0, p4 = 3'h0, ev_req = 3'h0;
    logic [15:0] per1 = 16'h0;
    logic [7:0]  per3 = 8'h0, per4 = 8'h0, cmp3 = 8'h0, cmp4 = 8'h0;
    logic [79:0] cmp1 = 80'h0;
    logic [4:0]  en1 = 5'h0, cap1 = 5'h0, fall1 = 5'h0, cap_lvl = 5'h0;
    logic        en3 = 1'b0, en4 = 1'b0, ir = 1'b0;
    logic [2:0]  ev_pin;
    logic [4:0]  cap_pin, pwm1, stb1;
    logic [15:0] cnt1;
    logic [79:0] capt1;
    logic [7:0]  cnt3, cnt4;
    logic        wr1, wr3, wr4, pwm3, pwm4, ir_out;
    int          n_fail = 0;
    int          check_count = 0;

    tpc_pin_model u_pins (.i_ref_clk(clk), .i_arst_n(rst_n),
        .i_ev_req(ev_req), .i_cap_lvl(cap_lvl), .o_ev_pin(ev_pin),
        .o_cap_pin(cap_pin));

    tpc_timer_group DUT (.i_ref_clk(clk), .i_arst_n(rst_n),
        .i_t1_mode(m1), .i_t1_presc(p1), .i_t1_period(per1),
        .i_t1_cmp(cmp1), .i_t1_ch_en(en1), .i_t1_ch_cap(cap1),
        .i_t1_cap_fall(fall1), .i_t3_mode(m3), .i_t3_presc(p3),
        .i_t3_period(per3), .i_t3_cmp(cmp3), .i_t3_ch_en(en3),
        .i_t4_mode(m4), .i_t4_presc(p4), .i_t4_period(per4),
        .i_t4_cmp(cmp4), .i_t4_ch_en(en4), .i_ir_en(ir),
        .i_t1_cap_pin(cap_pin), .i_t1_evt_pin(ev_pin[0]),
        .i_t3_evt_pin(ev_pin[1]), .i_t4_evt_pin(ev_pin[2]),
        .o_t1_count(cnt1), .o_t1_wrap(wr1), .o_t1_pwm(pwm1),
        .o_t1_capt(capt1), .o_t1_capt_stb(stb1), .o_t3_count(cnt3),
        .o_t3_wrap(wr3), .o_t3_pwm(pwm3), .o_t4_count(cnt4),
        .o_t4_wrap(wr4), .o_t4_pwm(pwm4), .o_ir_out(ir_out));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic restart;
        @(posedge clk) rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    function automatic logic [15:0] cnt_of(input int sel);
        case (sel)
            0: return cnt1;
            1: return {8'h0, cnt3};
            default: return {8'h0, cnt4};
        endcase
    endfunction

    // Wrap flag on top, PWM bits below
    function automatic logic [5:0] st_of(input int sel);
        case (sel)
            0: return {wr1, pwm1};
            1: return {wr3, 4'h0, pwm3};
            default: return {wr4, 4'h0, pwm4};
        endcase
    endfunction

    function automatic logic [15:0] cmp_of(input int sel, input int ch);
        case (sel)
            0: return cmp1[ch*16 +: 16];
            1: return {8'h0, cmp3};
            default: return {8'h0, cmp4};
        endcase
    endfunction

    // Lands on the first cycle a fresh 1 shows, to align the model
    task automatic wait_one(input int sel);
        logic [15:0] last;
        last = cnt_of(sel);
        for (int k = 0; k < 3000; k++) begin
            @(negedge clk);
            if (cnt_of(sel) === 16'h1 && last !== 16'h1) return;
            last = cnt_of(sel);
        end
        n_fail++;
        summarize();
    endtask

    task automatic run_cnt(input int sel, input int p, input int n,
                           input int ncyc);
        int         c;
        int         prev;
        logic [5:0] st;
        wait_one(sel);
        prev = 1;
        for (int j = 1; j < ncyc; j++) begin
            @(negedge clk);
            c = (1 + j / (1 << n)) % (p + 1);
            st = st_of(sel);
            chk(cnt_of(sel), c[15:0]);
            chk({15'h0, st[5]}, {15'h0, j % (1<<n) == 0 && c == 0});
            for (int ch = 0; ch < (sel == 0 ? 5 : 1); ch++) begin
                chk({15'h0, st[ch]}, {15'h0, prev < cmp_of(sel, ch)});
            end
            prev = c;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic scen_main(input int p, input int n, input logic [79:0] c);
        @(posedge clk);
        m1 <= 2'h1;
        p1 <= n[2:0];
        per1 <= p[15:0];
        cmp1 <= c;
        en1 <= 5'h1f;
        cap1 <= 5'h00;
        restart();
        run_cnt(0, p, n, 60);
    endtask

    task automatic scen_small(input int p, input int n,
                              input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        m3 <= 2'h1;
        m4 <= 2'h1;
        p3 <= n[2:0];
        p4 <= n[2:0];
        per3 <= p[7:0];
        per4 <= p[7:0];
        cmp3 <= a;
        cmp4 <= b;
        en3 <= 1'b1;
        en4 <= 1'b1;
        restart();
        run_cnt(1, p, n, 40);
        run_cnt(2, p, n, 40);
    endtask

    // Counts are left frozen for the capture scenario
    task automatic scen_event;
        @(posedge clk);
        m1 <= 2'h2;
        m3 <= 2'h2;
        m4 <= 2'h2;
        per1 <= 16'hffff;
        per3 <= 8'hff;
        per4 <= 8'hff;
        restart();
        repeat (4) @(posedge clk);
        for (int r = 0; r < 4; r++) begin
            ev_req <= {r < 4, r < 3, r < 2};
            @(posedge clk);
            ev_req <= 3'h0;
            repeat (5) @(posedge clk);
        end
        repeat (4) @(negedge clk);
        chk(cnt1, 16'h0002);
        chk({8'h0, cnt3}, 16'h0003);
        chk({8'h0, cnt4}, 16'h0004);
    endtask

    task automatic wait_stb(input int ch);
        for (int k = 0; k < 20; k++) begin
            @(negedge clk);
            if (stb1[ch] === 1'b1) return;
        end
        n_fail++;
        summarize();
    endtask

    task automatic scen_capture;
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            cap1 <= 5'h1f;
            en1 <= 5'h1f;
            fall1 <= {5{e[0]}};
            for (int ch = 0; ch < 5; ch++) begin
                @(posedge clk);
                cap_lvl[ch] <= ~e[0];
                wait_stb(ch);
                chk({11'h0, stb1}, 16'h1 << ch);
                chk(capt1[ch*16 +: 16], 16'h0002);
                chk({11'h0, pwm1}, 16'h0000);
                @(negedge clk);
                chk({11'h0, stb1}, 16'h0000);
            end
        end
    endtask

    // Own prescaler set slow on purpose: it must be ignored here
    task automatic scen_ir;
        logic [15:0] lc;
        logic        lw;
        logic        lp;
        int          hi;
        @(posedge clk);
        m1 <= 2'h1;
        p1 <= 3'h2;
        per1 <= 16'h0007;
        cmp1 <= 80'h3;
        en1 <= 5'h01;
        cap1 <= 5'h00;
        m3 <= 2'h1;
        p3 <= 3'h0;
        per3 <= 8'h03;
        cmp3 <= 8'h02;
        en3 <= 1'b1;
        ir <= 1'b1;
        restart();
        hi = 0;
        @(negedge clk);
        for (int j = 0; j < 200; j++) begin
            lc = cnt1;
            lw = wr3;
            lp = pwm1[0] & pwm3;
            @(negedge clk);
            chk({15'h0, cnt1 !== lc}, {15'h0, lw});
            chk({15'h0, ir_out}, {15'h0, lp});
            hi += (ir_out === 1'b1);
        end
        chk({15'h0, hi > 0}, 16'h0001);
        @(posedge clk);
        ir <= 1'b0;
        m3 <= 2'h0;
        repeat (3) @(negedge clk);
        chk({15'h0, ir_out}, 16'h0000);
        // Stop mode must freeze the count without clearing it
        lc = {8'h0, cnt3};
        repeat (8) @(negedge clk);
        chk({8'h0, cnt3}, lc);
    endtask

    initial begin
        #200_000;
        n_fail++;
        summarize();
    end

    initial begin
        scen_main(2, 0, {16'h4, 16'h3, 16'h2, 16'h1, 16'h0});
        scen_main(9, 0, {16'hc, 16'h9, 16'h5, 16'h3, 16'h0});
        scen_main(4, 2, {16'h5, 16'h4, 16'h3, 16'h2, 16'h1});
        scen_small(5, 0, 8'h00, 8'h03);
        scen_small(3, 1, 8'h04, 8'h02);
        scen_event();
        scen_capture();
        scen_ir();
        summarize();
    end
endmodule
`default_nettype wire

// ### testbench/tpc_pin_model.sv
// Pin-side model: event pulses and capture pin levels.
// Assumes one-cycle requests from the bench on i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module tpc_pin_model (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_arst_n,
    // Requests
    input  wire logic [2:0] i_ev_req,
    input  wire logic [4:0] i_cap_lvl,
    // Pins
    output logic      [2:0] o_ev_pin,
    output logic      [4:0] o_cap_pin
);
    logic [2:0] hold_ff;

    // Two cycles high so the synchroniser cannot miss a pulse
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hold_ff   <= 3'h0;
            o_ev_pin  <= 3'h0;
            o_cap_pin <= 5'h00;
        end else begin
            hold_ff   <= i_ev_req;
            o_ev_pin  <= i_ev_req | hold_ff;
            o_cap_pin <= i_cap_lvl;
        end
    end
endmodule
`default_nettype wire
